//--- src/eag_core.sv
// Behaviour
// - Stack pointer holds next free word; stack grows upward.
// - Pop predecrements pointer; push post-increments pointer.
// - Call push clears the pushed counter's top bit.
// - Exception push places status low onto the counter's top bit.
// - Stack limit has no reset value; unknown until written.
// - Stack limit bit zero always reads zero.
// - Every stack-pointer-based address is checked against the limit (core checks operand and push addresses; pop addresses only against 0x0800).
// - Push at limit is fine; next push raises stack error.
// - Stack pointer below 0x0800 raises stack error underflow.
// - Boot secure RAM only served to boot flash code when enabled (core checks operand addresses only, not push or pop addresses).
// - Segment secure RAM only served to secure flash code when enabled (core checks operand addresses only, not push or pop addresses).
// - File register address is 13 bits, first 8192 bytes.
// - File instructions use working register zero as default.
// - Three-operand: base register direct; operand two register/memory/literal.
// - Indirect address equals pointer register contents.
// - Post-modify uses pointer, then steps it by a constant.
// - Pre-modify steps pointer by signed constant, uses new value.
// - Indexed address is pointer plus base offset register.
// - Literal-offset address is pointer plus instruction literal.
// - Copy instruction adds indexed, literal offset, 8 and 16 bit literals.
// - Source and destination modes differ; one shared offset field (core takes separate off_sel and lit_off per request).
`timescale 1ns/1ps
module eag_core (
   input wire logic clk, // core clock
   input wire logic rst, // sync reset, high
   input eag_pkg::eag_req_t src_req, // source operand request
   input eag_pkg::eag_req_t dst_req, // destination operand request
   input eag_pkg::eag_stack_req_t stk_req, // push or pop
   input wire logic wr_en, // working register write
   input wire logic [3:0] wr_sel, // which working register
   input wire logic [15:0] wr_data, // value written
   input wire logic lim_wr, // stack limit write
   input wire logic [15:0] lim_data, // stack limit value
   input wire logic exec_boot, // code runs in boot flash
   input wire logic exec_secure, // code runs in secure flash
   input eag_pkg::eag_seg_t boot_secure_ram, // boot segment window
   input eag_pkg::eag_seg_t segment_secure_ram, // secure segment window
   input wire logic trap_ack, // exception logic took trap
   output eag_pkg::eag_ea_t src_ea, // source address or literal
   output eag_pkg::eag_ea_t dst_ea, // destination address
   output logic [15:0] stk_addr, // stack access address
   output logic [15:0] stk_wdata, // pushed word
   output logic stk_valid, // stack access valid
   output logic access_denied, // secure RAM refusal
   output logic stack_trap, // stack error trap request
   output logic stall, // completion blocked
   output logic [15:0] stack_pointer_reg // current stack pointer
);
   typedef struct packed {
      logic [eag_pkg::NREG-1:0][15:0] work;
      logic [15:0] lim;
      eag_pkg::eag_ea_t src;
      eag_pkg::eag_ea_t dst;
      logic [15:0] saddr;
      logic [15:0] swdata;
      logic svalid;
      logic denied;
      logic trap;
   } eag_state_t;

   eag_state_t state_reg, state_next;

   function automatic logic [15:0] lit_ext(input eag_pkg::eag_req_t r);
      case (r.lit_w)
         eag_pkg::EAG_LIT5: lit_ext = {11'h000, r.literal[4:0]};
         eag_pkg::EAG_LIT10: lit_ext = {6'h00, r.literal[9:0]};
         eag_pkg::EAG_LIT8: lit_ext = {8'h00, r.literal[7:0]};
         default: lit_ext = r.literal;
      endcase
   endfunction

   function automatic logic denied_fn(input logic [15:0] a,
      input eag_pkg::eag_seg_t bs, input eag_pkg::eag_seg_t ss,
      input logic eb, input logic es);
      logic in_bs;
      logic in_ss;
      in_bs = bs.en && a >= bs.base && a <= bs.top;
      in_ss = ss.en && a >= ss.base && a <= ss.top;
      denied_fn = (in_bs && !eb) || (in_ss && !es);
   endfunction

   // Computes address; ptr/new pointer value for modify modes
   task automatic gen_ea(input eag_pkg::eag_req_t r,
      input logic [eag_pkg::NREG-1:0][15:0] w,
      output eag_pkg::eag_ea_t ea, output logic upd,
      output logic [15:0] newp);
      logic [15:0] p;
      logic [15:0] step;
      p = w[r.ptr_sel];
      step = r.byte_op ? eag_pkg::BYTE_STEP : eag_pkg::WORD_STEP;
      ea.valid = r.valid;
      ea.is_mem = 1'b1;
      ea.operand = 16'h0000;
      ea.addr = p;
      upd = 1'b0;
      newp = p;
      case (r.mode)
         eag_pkg::EAG_FILE_DIRECT:
         begin
            ea.addr = {3'h0, r.file_addr};
            ea.operand = w[eag_pkg::WZ_IDX];
         end
         eag_pkg::EAG_REG_DIRECT:
         begin
            ea.is_mem = 1'b0;
            ea.operand = p;
         end
         eag_pkg::EAG_INDIRECT: ea.addr = p;
         eag_pkg::EAG_POST_MOD:
         begin
            ea.addr = p;
            upd = 1'b1;
            newp = r.dec_mod ? p - step : p + step;
         end
         eag_pkg::EAG_PRE_MOD:
         begin
            newp = r.dec_mod ? p - step : p + step;
            ea.addr = newp;
            upd = 1'b1;
         end
         // Each operand request carries its own offset fields (off_sel, lit_off)
         eag_pkg::EAG_INDEXED: ea.addr = p + w[r.off_sel];
         eag_pkg::EAG_LIT_OFFSET:
            ea.addr = p + {{11{r.lit_off[4]}}, r.lit_off};
         eag_pkg::EAG_LITERAL:
         begin
            ea.is_mem = 1'b0;
            ea.operand = lit_ext(r);
         end
         default: ea.addr = p;
      endcase
      if (!r.valid)
      begin
         upd = 1'b0;
      end
   endtask

   logic [15:0] sp_now;
   assign sp_now = state_reg.work[eag_pkg::SP_IDX];

   always_comb
   begin
      eag_pkg::eag_ea_t se;
      eag_pkg::eag_ea_t de;
      logic su;
      logic du;
      logic [15:0] sn;
      logic [15:0] dn;
      logic [15:0] sp;
      logic hold;
      logic err;
      logic chk_sp;
      se = '0;
      de = '0;
      su = 1'b0;
      du = 1'b0;
      sn = 16'h0000;
      dn = 16'h0000;
      sp = 16'h0000;
      err = 1'b0;
      chk_sp = 1'b0;
      state_next = state_reg;
      state_next.svalid = 1'b0;
      state_next.src.valid = 1'b0;
      state_next.dst.valid = 1'b0;
      hold = state_reg.trap;
      if (state_reg.trap && trap_ack)
      begin
         state_next.trap = 1'b0;
      end
      if (lim_wr)
      begin
         state_next.lim = {lim_data[15:1], 1'b0};
      end
      if (!hold)
      begin
         gen_ea(src_req, state_reg.work, se, su, sn);
         gen_ea(dst_req, state_reg.work, de, du, dn);
         state_next.src = se;
         state_next.dst = de;
         if (su)
         begin
            state_next.work[src_req.ptr_sel] = sn;
         end
         if (du)
         begin
            state_next.work[dst_req.ptr_sel] = dn;
         end
         // Any stack-pointer EA is limit checked
         if (se.valid && se.is_mem && src_req.ptr_sel == eag_pkg::SP_IDX
            && src_req.mode != eag_pkg::EAG_FILE_DIRECT)
         begin
            chk_sp = se.addr > state_reg.lim;
         end
         if (de.valid && de.is_mem && dst_req.ptr_sel == eag_pkg::SP_IDX
            && dst_req.mode != eag_pkg::EAG_FILE_DIRECT)
         begin
            chk_sp = chk_sp || de.addr > state_reg.lim;
         end
         sp = state_next.work[eag_pkg::SP_IDX];
         if (stk_req.valid && stk_req.op == eag_pkg::EAG_STK_PUSH)
         begin
            state_next.svalid = 1'b1;
            state_next.saddr = sp;
            case (stk_req.src)
               eag_pkg::EAG_PUSH_CALL:
                  state_next.swdata = {1'b0, stk_req.pc[14:0]};
               eag_pkg::EAG_PUSH_EXC:
                  state_next.swdata = {stk_req.status_low,
                     stk_req.pc[22:15]};
               default: state_next.swdata = stk_req.data;
            endcase
            // Equal to limit is allowed; beyond it traps
            err = sp > state_reg.lim;
            sp = sp + eag_pkg::WORD_STEP;
         end
         else if (stk_req.valid && stk_req.op == eag_pkg::EAG_STK_POP)
         begin
            sp = sp - eag_pkg::WORD_STEP;
            state_next.svalid = 1'b1;
            state_next.saddr = sp;
         end
         state_next.work[eag_pkg::SP_IDX] = {sp[15:1], 1'b0};
         if (wr_en)
         begin
            state_next.work[wr_sel] = wr_data;
         end
         err = err || chk_sp || sp < eag_pkg::STACK_FLOOR;
         state_next.trap = err;
         state_next.denied =
            (se.valid && se.is_mem && denied_fn(se.addr, boot_secure_ram,
               segment_secure_ram, exec_boot, exec_secure))
            || (de.valid && de.is_mem && denied_fn(de.addr, boot_secure_ram,
               segment_secure_ram, exec_boot, exec_secure));
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // Limit left untouched by reset on purpose
         state_reg.work <= '0;
         state_reg.work[eag_pkg::SP_IDX] <= eag_pkg::SP_RESET;
         state_reg.src <= '0;
         state_reg.dst <= '0;
         state_reg.saddr <= 16'h0000;
         state_reg.swdata <= 16'h0000;
         state_reg.svalid <= 1'b0;
         state_reg.denied <= 1'b0;
         state_reg.trap <= 1'b0;
         state_reg.lim <= state_next.lim;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign src_ea = state_reg.src;
   assign dst_ea = state_reg.dst;
   assign stk_addr = state_reg.saddr;
   assign stk_wdata = state_reg.swdata;
   assign stk_valid = state_reg.svalid;
   assign access_denied = state_reg.denied;
   assign stack_trap = state_reg.trap;
   assign stall = state_reg.trap;
   assign stack_pointer_reg = sp_now;

   chk_trap_hold: assert property (@(posedge clk) disable iff (rst)
      stack_trap && !trap_ack |=> stack_trap)
      else $error("stack trap dropped before ack");
   chk_lim_bit0: assert property (@(posedge clk) disable iff (rst)
      $past(lim_wr) |-> state_reg.lim[0] == 1'b0)
      else $error("stack limit bit zero set");
   chk_push_addr: assert property (@(posedge clk) disable iff (rst)
      stk_req.valid && stk_req.op == eag_pkg::EAG_STK_PUSH && !stall
      && !wr_en |=> stk_addr == $past(sp_now)
      && sp_now == $past(sp_now) + 16'h0002)
      else $error("push address or increment wrong");
   chk_pop_addr: assert property (@(posedge clk) disable iff (rst)
      stk_req.valid && stk_req.op == eag_pkg::EAG_STK_POP && !stall
      && !wr_en |=> stk_addr == sp_now
      && sp_now == $past(sp_now) - 16'h0002)
      else $error("pop predecrement wrong");
   chk_call_msb: assert property (@(posedge clk) disable iff (rst)
      stk_req.valid && stk_req.src == eag_pkg::EAG_PUSH_CALL && !stall
      && stk_req.op == eag_pkg::EAG_STK_PUSH |=> !stk_wdata[15])
      else $error("call push top bit set");
   chk_under_trap: assert property (@(posedge clk) disable iff (rst)
      !stall && !wr_en && !stk_req.valid && !src_req.valid && !dst_req.valid
      && sp_now < 16'h0800 |=> stack_trap)
      else $error("underflow not trapped");
   chk_indirect_ea: assert property (@(posedge clk) disable iff (rst)
      src_req.valid && src_req.mode == eag_pkg::EAG_INDIRECT && !stall
      |=> src_ea.addr == $past(state_reg.work[src_req.ptr_sel]))
      else $error("indirect address wrong");
   chk_file_addr: assert property (@(posedge clk) disable iff (rst)
      src_req.valid && src_req.mode == eag_pkg::EAG_FILE_DIRECT && !stall
      |=> src_ea.addr[15:13] == 3'h0)
      else $error("file address beyond 13 bits");
endmodule

//--- common/eag_pkg.sv
package eag_pkg;
   localparam int DW = 16;
   localparam int NREG = 16;
   localparam logic [3:0] SP_IDX = 4'hF;
   localparam logic [3:0] WZ_IDX = 4'h0;
   localparam logic [DW-1:0] STACK_FLOOR = 16'h0800;
   localparam logic [DW-1:0] WORD_STEP = 16'h0002;
   localparam logic [DW-1:0] BYTE_STEP = 16'h0001;
   localparam int FILE_AW = 13;
   localparam logic [DW-1:0] SP_RESET = 16'h0800;
   localparam logic [DW-1:0] SEG_RESET = 16'h0000;

   typedef enum logic [2:0] {
      EAG_FILE_DIRECT,
      EAG_REG_DIRECT,
      EAG_INDIRECT,
      EAG_POST_MOD,
      EAG_PRE_MOD,
      EAG_INDEXED,
      EAG_LIT_OFFSET,
      EAG_LITERAL
   } eag_mode_t;

   typedef enum logic [1:0] {
      EAG_STK_NONE,
      EAG_STK_PUSH,
      EAG_STK_POP
   } eag_stk_t;

   typedef enum logic [1:0] {
      EAG_PUSH_DATA,
      EAG_PUSH_CALL,
      EAG_PUSH_EXC
   } eag_pushsrc_t;

   typedef enum logic [1:0] {
      EAG_LIT5,
      EAG_LIT8,
      EAG_LIT10,
      EAG_LIT16
   } eag_litw_t;

   // One addressing request from the decoder
   typedef struct packed {
      logic valid;
      eag_mode_t mode;
      logic [3:0] ptr_sel;
      logic [3:0] off_sel;
      logic dec_mod;
      logic byte_op;
      logic signed [4:0] lit_off;
      logic [FILE_AW-1:0] file_addr;
      logic [15:0] literal;
      eag_litw_t lit_w;
   } eag_req_t;

   typedef struct packed {
      logic valid;
      eag_stk_t op;
      eag_pushsrc_t src;
      logic [22:0] pc;
      logic [7:0] status_low;
      logic [15:0] data;
   } eag_stack_req_t;

   typedef struct packed {
      logic en;
      logic [15:0] base;
      logic [15:0] top;
   } eag_seg_t;

   typedef struct packed {
      logic valid;
      logic is_mem;
      logic [15:0] addr;
      logic [15:0] operand;
   } eag_ea_t;
endpackage

//--- tb/eag_trap_host.sv
`timescale 1ns/1ps
module eag_trap_host (
   clk, // core clock
   rst, // sync reset, high
   stack_trap, // trap request from the core
   ack_wait, // cycles to wait before taking the trap
   trap_ack // trap taken, one-cycle pulse
);
   input wire logic clk;
   input wire logic rst;
   input wire logic stack_trap;
   input wire logic [3:0] ack_wait;
   output logic trap_ack;
   logic [3:0] cnt_reg;
   // Never acks without a pending request, as the real exception logic
   always_ff @(posedge clk)
   begin
      if (rst || !stack_trap || trap_ack)
      begin
         cnt_reg <= 4'h0;
         trap_ack <= 1'b0;
      end
      else if (cnt_reg == ack_wait)
      begin
         trap_ack <= 1'b1;
      end
      else
      begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule

//--- tb/eag_core_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) \
   begin \
      cmp_count++; \
      if ((a) !== (b)) \
      begin \
         errors++; \
         $display("wrong value t=%0t got %h exp %h", $time, a, b); \
      end \
   end
module eag_core_bench;
   logic clk;
   logic rst;
   eag_pkg::eag_req_t src_req;
   eag_pkg::eag_req_t dst_req;
   eag_pkg::eag_stack_req_t stk_req;
   logic wr_en;
   logic [3:0] wr_sel;
   logic [15:0] wr_data;
   logic lim_wr;
   logic [15:0] lim_data;
   logic exec_boot;
   logic exec_secure;
   eag_pkg::eag_seg_t boot_secure_ram;
   eag_pkg::eag_seg_t segment_secure_ram;
   logic trap_ack;
   logic [3:0] ack_wait;
   eag_pkg::eag_ea_t src_ea;
   eag_pkg::eag_ea_t dst_ea;
   logic [15:0] stk_addr;
   logic [15:0] stk_wdata;
   logic stk_valid;
   logic access_denied;
   logic stack_trap;
   logic stall;
   logic [15:0] sp;
   int errors;
   int cmp_count;

   eag_core dut (.clk(clk), .rst(rst), .src_req(src_req),
      .dst_req(dst_req), .stk_req(stk_req), .wr_en(wr_en),
      .wr_sel(wr_sel), .wr_data(wr_data), .lim_wr(lim_wr),
      .lim_data(lim_data), .exec_boot(exec_boot),
      .exec_secure(exec_secure), .boot_secure_ram(boot_secure_ram),
      .segment_secure_ram(segment_secure_ram), .trap_ack(trap_ack),
      .src_ea(src_ea), .dst_ea(dst_ea), .stk_addr(stk_addr),
      .stk_wdata(stk_wdata), .stk_valid(stk_valid),
      .access_denied(access_denied), .stack_trap(stack_trap),
      .stall(stall), .stack_pointer_reg(sp));

   eag_trap_host host (.clk(clk), .rst(rst), .stack_trap(stack_trap),
      .ack_wait(ack_wait), .trap_ack(trap_ack));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic test_done;
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic set_work(input logic [3:0] s, input logic [15:0] d);
      @(negedge clk);
      wr_en = 1'b1;
      wr_sel = s;
      wr_data = d;
      @(negedge clk);
      wr_en = 1'b0;
   endtask

   task automatic setlim(input logic [15:0] d);
      @(negedge clk);
      lim_wr = 1'b1;
      lim_data = d;
      @(negedge clk);
      lim_wr = 1'b0;
      @(negedge clk); // Idle gap before stack pointer read
   endtask

   task automatic stk(input eag_pkg::eag_stk_t op,
      input eag_pkg::eag_pushsrc_t s = eag_pkg::EAG_PUSH_DATA,
      input logic [22:0] pc = 23'h0, input logic [7:0] sl = 8'h00,
      input logic [15:0] d = 16'h0000);
      @(negedge clk);
      stk_req = '{1'b1, op, s, pc, sl, d};
      @(negedge clk);
      stk_req.valid = 1'b0;
   endtask

   task automatic ea(input eag_pkg::eag_mode_t m, input logic [3:0] p,
      input logic [3:0] o = 4'h0, input logic dm = 1'b0,
      input logic signed [4:0] lo = 5'sh00, input logic both = 1'b0);
      @(negedge clk);
      src_req.mode = m;
      src_req.ptr_sel = p;
      src_req.off_sel = o;
      src_req.dec_mod = dm;
      src_req.lit_off = lo;
      src_req.valid = 1'b1;
      dst_req = src_req;
      dst_req.ptr_sel = 4'h2;
      dst_req.valid = both;
      @(negedge clk);
      src_req.valid = 1'b0;
      dst_req.valid = 1'b0;
   endtask

   // Bounded so a lost acknowledge ends the run instead of hanging
   task automatic wait_clear;
      int n = 0;
      while (stall !== 1'b0 && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      if (stall !== 1'b0)
      begin
         errors++;
         test_done;
      end
   endtask

   task automatic t_push_pop;
      stk(eag_pkg::EAG_STK_PUSH, eag_pkg::EAG_PUSH_DATA, 23'h0, 8'h00,
         16'hA5A5);
      `CHK(stk_valid, 1'b1)
      `CHK(stk_addr, 16'h0800)
      `CHK(stk_wdata, 16'hA5A5)
      `CHK(sp, 16'h0802)
      stk(eag_pkg::EAG_STK_PUSH, eag_pkg::EAG_PUSH_CALL, 23'h40F234);
      `CHK(stk_wdata, 16'h7234)
      stk(eag_pkg::EAG_STK_PUSH, eag_pkg::EAG_PUSH_EXC, 23'h40F234, 8'h5C);
      `CHK(stk_wdata, 16'h5C81)
      `CHK(stk_addr, 16'h0804)
      stk(eag_pkg::EAG_STK_POP);
      `CHK(stk_addr, 16'h0804)
      `CHK(sp, 16'h0804)
      stk(eag_pkg::EAG_STK_POP);
      stk(eag_pkg::EAG_STK_POP);
      `CHK(sp, 16'h0800)
      `CHK(stack_trap, 1'b0)
   endtask

   // Underflow re-raises every free cycle, so the pointer is
   // repaired in the one cycle between acknowledge and re-raise
   task automatic t_underflow;
      ack_wait = 4'h6;
      stk(eag_pkg::EAG_STK_POP);
      `CHK(sp, 16'h07FE)
      `CHK(stack_trap, 1'b1)
      `CHK(stall, 1'b1)
      stk(eag_pkg::EAG_STK_PUSH);
      `CHK(stk_valid, 1'b0)
      `CHK(sp, 16'h07FE)
      wait_clear;
      `CHK(stack_trap, 1'b0)
      wr_en = 1'b1;
      wr_sel = 4'hF;
      wr_data = 16'h0800;
      @(negedge clk);
      wr_en = 1'b0;
      `CHK(sp, 16'h0800)
      `CHK(stack_trap, 1'b1)
      wait_clear;
      @(negedge clk);
      `CHK(stack_trap, 1'b0)
   endtask

   task automatic t_limit;
      ack_wait = 4'h1;
      setlim(16'h0803);
      stk(eag_pkg::EAG_STK_PUSH);
      stk(eag_pkg::EAG_STK_PUSH);
      `CHK(stk_addr, 16'h0802)
      `CHK(stack_trap, 1'b0)
      stk(eag_pkg::EAG_STK_PUSH);
      `CHK(stack_trap, 1'b1)
      wait_clear;
      set_work(4'hF, 16'h0802);
      ea(eag_pkg::EAG_LIT_OFFSET, 4'hF, 4'h0, 1'b0, 5'sh01);
      `CHK(src_ea.addr, 16'h0803)
      `CHK(stack_trap, 1'b1)
      wait_clear;
      setlim(16'hFFFE);
      set_work(4'hF, 16'h0800);
   endtask

   task automatic t_modes;
      set_work(4'h0, 16'h5A5A);
      set_work(4'h1, 16'h1234);
      set_work(4'h2, 16'h0010);
      src_req.file_addr = 13'h1FFF;
      ea(eag_pkg::EAG_FILE_DIRECT, 4'h0);
      `CHK(src_ea.addr, 16'h1FFF)
      `CHK(src_ea.is_mem, 1'b1)
      `CHK(src_ea.operand, 16'h5A5A)
      ea(eag_pkg::EAG_POST_MOD, 4'h1);
      `CHK(src_ea.addr, 16'h1234)
      ea(eag_pkg::EAG_INDIRECT, 4'h1);
      `CHK(src_ea.addr, 16'h1236)
      ea(eag_pkg::EAG_PRE_MOD, 4'h1, 4'h0, 1'b1);
      `CHK(src_ea.addr, 16'h1234)
      ea(eag_pkg::EAG_INDEXED, 4'h1, 4'h2, 1'b0, 5'sh00, 1'b1);
      `CHK(src_ea.addr, 16'h1244)
      `CHK(dst_ea.addr, 16'h0020)
      ea(eag_pkg::EAG_LIT_OFFSET, 4'h1, 4'h0, 1'b0, 5'sh1C);
      `CHK(src_ea.addr, 16'h1230)
      src_req.byte_op = 1'b1;
      ea(eag_pkg::EAG_POST_MOD, 4'h1, 4'h0, 1'b1);
      `CHK(src_ea.addr, 16'h1234)
      ea(eag_pkg::EAG_INDIRECT, 4'h1);
      `CHK(src_ea.addr, 16'h1233)
      src_req.byte_op = 1'b0;
      ea(eag_pkg::EAG_REG_DIRECT, 4'h2);
      `CHK(src_ea.operand, 16'h0010)
      `CHK(src_ea.is_mem, 1'b0)
      src_req.literal = 16'h12AB;
      src_req.lit_w = eag_pkg::EAG_LIT16;
      ea(eag_pkg::EAG_LITERAL, 4'h0);
      `CHK(src_ea.operand, 16'h12AB)
      src_req.lit_w = eag_pkg::EAG_LIT8;
      ea(eag_pkg::EAG_LITERAL, 4'h0);
      `CHK(src_ea.operand, 16'h00AB)
      src_req.lit_w = eag_pkg::EAG_LIT5;
      ea(eag_pkg::EAG_LITERAL, 4'h0);
      `CHK(src_ea.operand, 16'h000B)
      src_req.lit_w = eag_pkg::EAG_LIT10;
      ea(eag_pkg::EAG_LITERAL, 4'h0);
      `CHK(src_ea.operand, 16'h02AB)
   endtask

   task automatic t_secure;
      set_work(4'h3, 16'h1010);
      for (int i = 0; i < 4; i++)
      begin
         boot_secure_ram.en = (i < 2);
         segment_secure_ram.en = (i >= 2);
         exec_boot = i[0];
         exec_secure = i[0];
         ea(eag_pkg::EAG_INDIRECT, 4'h3);
         `CHK(access_denied, !i[0])
      end
   endtask

   initial
   begin
      errors = 0;
      cmp_count = 0;
      rst = 1'b1;
      src_req = '0;
      dst_req = '0;
      stk_req = '0;
      wr_en = 1'b0;
      wr_sel = 4'h0;
      wr_data = 16'h0000;
      lim_wr = 1'b0;
      lim_data = 16'h0000;
      exec_boot = 1'b0;
      exec_secure = 1'b0;
      boot_secure_ram = '{1'b0, 16'h1000, 16'h10FF};
      segment_secure_ram = '{1'b0, 16'h1000, 16'h10FF};
      ack_wait = 4'h1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
      `CHK(sp, eag_pkg::SP_RESET)
      `CHK(stack_trap, 1'b0)
      setlim(16'hFFFE);
      t_push_pop;
      t_underflow;
      t_limit;
      t_modes;
      t_secure;
      test_done;
   end
endmodule
